// *** src/ictl_div.sv ***
// ictl_div: readout tick divider, one-cycle pulse every CYC clocks.
// assumes clk_sys and an asynchronous active-low reset.
`timescale 1ns/1ps
module ictl_div #(
	parameter int unsigned CYC = 50
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic resetn,
	// tick
	output logic      tick
);
	import ictl_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} ictl_div_s;

	ictl_div_s st_ff;
	ictl_div_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		if (st_ff.cnt == 16'(CYC - 1)) begin
			nxt_st.cnt = 16'h0000;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = 16'(st_ff.cnt + 16'h0001);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick = st_ff.tick;
endmodule : ictl_div

// *** src/ictl_engine.sv ***
// ictl_engine: command telegram engine for two head channels.
// assumes head logic and telegram framer run on clk_sys; addrSel is a pin.
`timescale 1ns/1ps
// Behaviour
// - command gets one confirmation, none under MODBUS, then a response
// - enhanced commands may give many responses but one confirmation
// - command: length, code, channel/toggle, two parameters, write data
// - confirmation: length, code, chan/toggle, FFh, counter, 00h fill
// - response: length, code, channel/toggle, status, counter, read data
// - command runs only when field differs from the previous readout
// - new command sets status FFh, bumps counter; final status follows
// - response toggle bit equals the command's toggle bit
// - each new result overwrites and bumps counter; wrap goes to 01h
// - single mode runs once and answers at once, then idles
// - enhanced mode stays active until cancelled or an error ends it
// - enhanced mode reports only changed tags, never one tag twice
// - tag leaving read range gives a response with status 5
// - status matching one of five channel codes raises a mail request
// - selector at D during startup selects DHCP network settings
// - saving network settings restarts; settings apply after restart
// - length field holds N+1 split into high and low byte
// - channel/toggle byte: bit zero toggle, channel number above
// - confirmation length under plain TCP is six
module ictl_engine (
	// clock and reset
	input  wire logic                                  clk_sys,
	input  wire logic                                  resetn,
	// register port
	input  wire logic [ictl_pkg::ADDR_W-1:0]           regAddr,
	input  wire logic [31:0]                           regWrData,
	input  wire logic                                  regWrEn,
	input  wire logic                                  regRdEn,
	output logic      [31:0]                           regRdData,
	// address selector pins
	input  wire logic [3:0]                            addrSel,
	// head execution side
	output logic      [ictl_pkg::NUM_CH-1:0]           execStart,
	output logic      [ictl_pkg::NUM_CH-1:0][7:0]      execCode,
	output logic      [ictl_pkg::NUM_CH-1:0][15:0]     execParam,
	input  wire logic [ictl_pkg::NUM_CH-1:0]           headDone,
	input  wire logic [ictl_pkg::NUM_CH-1:0][7:0]      headStatus,
	input  wire logic [ictl_pkg::NUM_CH-1:0][31:0]     headData,
	input  wire logic [ictl_pkg::NUM_CH-1:0]           tagSeen,
	input  wire logic [ictl_pkg::NUM_CH-1:0]           tagLeave,
	input  wire logic [ictl_pkg::NUM_CH-1:0][31:0]     tagId,
	// telegram output
	output logic                                       txValid,
	output logic                                       txIsConf,
	output logic                                       txChan,
	output logic                                       txHasLen,
	output logic      [15:0]                           txLength,
	output logic      [7:0]                            txCode,
	output logic      [7:0]                            txChanTog,
	output logic      [7:0]                            txStatus,
	output logic      [7:0]                            txCounter,
	output logic      [31:0]                           txData,
	// notification and network
	output logic                                       mailReq,
	output logic                                       mailChan,
	output logic                                       dhcpMode,
	output logic      [31:0]                           netIp,
	output logic                                       restartReq
);
	import ictl_pkg::*;

	typedef struct packed {
		logic [31:0]                     rdData;
		logic [1:0]                      proto;
		logic [NUM_CH-1:0]               enhSel;
		logic [NUM_CH-1:0][31:0]         field;
		logic [NUM_CH-1:0][31:0]         seen;
		logic [NUM_CH-1:0][7:0]          status;
		logic [NUM_CH-1:0][7:0]          counter;
		logic [NUM_CH-1:0][31:0]         rspData;
		logic [NUM_CH-1:0][31:0]         lastTag;
		logic [NUM_CH-1:0]               busy;
		logic [NUM_CH-1:0]               cmdEnh;
		logic [NUM_CH-1:0]               enhAct;
		logic [NUM_CH-1:0]               tagVld;
		logic [NUM_CH-1:0]               pendConf;
		logic [NUM_CH-1:0]               pendRsp;
		logic [NUM_CH-1:0]               execStart;
		logic [NUM_CH-1:0][MAIL_CODES-1:0][7:0] mailCode;
		logic [NUM_CH-1:0][MAIL_CODES-1:0]      mailEn;
		logic                            txValid;
		logic                            txIsConf;
		logic                            txHasLen;
		logic                            txChan;
		logic [15:0]                     txLength;
		logic [7:0]                      txCode;
		logic [7:0]                      txChanTog;
		logic [7:0]                      txStatus;
		logic [7:0]                      txCounter;
		logic [31:0]                     txData;
		logic                            mailReq;
		logic                            mailChan;
		logic [3:0]                      sel1;
		logic [3:0]                      sel2;
		logic [1:0]                      strapCnt;
		logic                            dhcp;
		logic [31:0]                     ipStage;
		logic [31:0]                     ipActive;
		logic                            restartPend;
		logic                            restartReq;
	} ictl_st_s;

	ictl_st_s          st_ff;
	ictl_st_s          nxt_st;
	logic              scanTick;
	logic [NUM_CH-1:0] mailHit;
	logic [NUM_CH-1:0] newCmd;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] cntNext(input logic [7:0] c);
		cntNext = (c == CNT_LAST) ? CNT_START : 8'(c + 8'h01);
	endfunction : cntNext

	function automatic logic [6:0] chanNum(input logic [7:0] ct);
		chanNum = ct[7:1];
	endfunction : chanNum

	function automatic logic [7:0] mailOfs(input int c, input logic hi);
		mailOfs = 8'(OFS_MAIL + 8'(c) * MAIL_STEP) | (hi ? MAIL_HI : 8'h00);
	endfunction : mailOfs

	// ------------------------------------------------------------
	// readout tick and mail compare
	// ------------------------------------------------------------
	ictl_div #(.CYC(SCAN_CYC)) u_div (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.tick    (scanTick)
	);

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_mail
			ictl_match u_match (
				.status (st_ff.status[g]),
				.codes  (st_ff.mailCode[g]),
				.enable (st_ff.mailEn[g]),
				.hit    (mailHit[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		logic [NUM_CH-1:0] cancel;
		logic              sent;
		logic [6:0]        cn;
		nxt_st = st_ff;
		cancel = '0;
		sent = 1'b0;
		cn = chanNum(regWrData[CMD_CT_LSB +: 8]);
		newCmd = '0;
		nxt_st.rdData = 32'h0000_0000;
		nxt_st.execStart = '0;
		nxt_st.txValid = 1'b0;
		nxt_st.mailReq = 1'b0;
		nxt_st.restartReq = 1'b0;
		nxt_st.sel1 = addrSel;
		nxt_st.sel2 = st_ff.sel1;
		if (st_ff.strapCnt <= STRAP_WAIT) begin
			nxt_st.strapCnt = 2'(st_ff.strapCnt + 2'h1);
			nxt_st.dhcp = (st_ff.sel2 == SEL_DHCP);
		end
		if (regWrEn) begin
			case (regAddr)
				OFS_CTRL: begin
					nxt_st.proto = regWrData[CTRL_PROTO_LSB +: 2];
					nxt_st.enhSel = regWrData[CTRL_ENH_LSB +: NUM_CH];
					cancel = regWrData[CTRL_CANCEL_LSB +: NUM_CH];
				end
				OFS_CMD: begin
					if (cn >= 7'd1 && cn <= 7'(NUM_CH)) begin
						nxt_st.field[1'(cn - 7'd1)] = regWrData;
					end
				end
				OFS_NETIP: nxt_st.ipStage = regWrData;
				OFS_SAVE: nxt_st.restartPend = 1'b1;
				default: begin
					for (int c = 0; c < NUM_CH; c++) begin
						if (regAddr == mailOfs(c, 1'b0)) begin
							nxt_st.mailCode[c][3:0] = regWrData;
						end
						if (regAddr == mailOfs(c, 1'b1)) begin
							nxt_st.mailCode[c][4] = regWrData[7:0];
							nxt_st.mailEn[c] =
								regWrData[MAIL_MASK_LSB +: MAIL_CODES];
						end
					end
				end
			endcase
		end
		if (regRdEn) begin
			case (regAddr)
				OFS_CTRL: begin
					nxt_st.rdData[CTRL_PROTO_LSB +: 2] = st_ff.proto;
					nxt_st.rdData[CTRL_ENH_LSB +: NUM_CH] = st_ff.enhSel;
					nxt_st.rdData[CTRL_DHCP_BIT] = st_ff.dhcp;
				end
				OFS_CMD: nxt_st.rdData = st_ff.field[0];
				OFS_NETIP: nxt_st.rdData = st_ff.ipStage;
				OFS_NETAC: nxt_st.rdData = st_ff.ipActive;
				default: begin
					for (int c = 0; c < NUM_CH; c++) begin
						if (regAddr == (c == 0 ? OFS_STAT0 : OFS_STAT1)) begin
							nxt_st.rdData[7:0] = st_ff.status[c];
							nxt_st.rdData[STAT_CNT_LSB +: 8] = st_ff.counter[c];
							nxt_st.rdData[STAT_BUSY_BIT] = st_ff.busy[c];
							nxt_st.rdData[STAT_ENH_BIT] = st_ff.enhAct[c];
							nxt_st.rdData[STAT_TAG_BIT] = st_ff.tagVld[c];
						end
						if (regAddr == mailOfs(c, 1'b0)) begin
							nxt_st.rdData = st_ff.mailCode[c][3:0];
						end
						if (regAddr == mailOfs(c, 1'b1)) begin
							nxt_st.rdData[7:0] = st_ff.mailCode[c][4];
							nxt_st.rdData[MAIL_MASK_LSB +: MAIL_CODES] =
								st_ff.mailEn[c];
						end
					end
				end
			endcase
		end
		// telegram arbiter: channel 0 first, confirmation ahead of response within a channel
		for (int c = 0; c < NUM_CH; c++) begin
			if (!sent && (st_ff.pendConf[c] || st_ff.pendRsp[c])) begin
				sent = 1'b1;
				nxt_st.txValid = 1'b1;
				nxt_st.txChan = 1'(c);
				nxt_st.txHasLen = (st_ff.proto != PROTO_CYCLIC);
				nxt_st.txCode = st_ff.seen[c][7:0];
				nxt_st.txChanTog = st_ff.seen[c][CMD_CT_LSB +: 8];
				nxt_st.txCounter = st_ff.counter[c];
				if (st_ff.pendConf[c]) begin
					nxt_st.pendConf[c] = 1'b0;
					nxt_st.txIsConf = 1'b1;
					nxt_st.txLength = CONF_LEN;
					nxt_st.txStatus = STATUS_BUSY;
					nxt_st.txData = FILL_DATA;
				end else begin
					nxt_st.pendRsp[c] = 1'b0;
					nxt_st.txIsConf = 1'b0;
					nxt_st.txLength = RSP_LEN;
					nxt_st.txStatus = st_ff.status[c];
					nxt_st.txData = st_ff.rspData[c];
					nxt_st.mailReq = mailHit[c];
					nxt_st.mailChan = 1'(c);
				end
			end
		end
		// per-channel command handling
		for (int c = 0; c < NUM_CH; c++) begin
			if (cancel[c]) begin
				nxt_st.enhAct[c] = 1'b0;
			end
			newCmd[c] = scanTick && !st_ff.restartPend &&
				(st_ff.field[c] != st_ff.seen[c]);
			if (newCmd[c]) begin
				nxt_st.seen[c] = st_ff.field[c];
				nxt_st.status[c] = STATUS_BUSY;
				nxt_st.counter[c] = cntNext(st_ff.counter[c]);
				nxt_st.execStart[c] = 1'b1;
				nxt_st.busy[c] = 1'b1;
				nxt_st.cmdEnh[c] = st_ff.enhSel[c];
				nxt_st.enhAct[c] = 1'b0;
				nxt_st.tagVld[c] = 1'b0;
				nxt_st.pendRsp[c] = 1'b0;
				nxt_st.pendConf[c] = (st_ff.proto != PROTO_MODBUS);
			end else if (headDone[c] && (st_ff.busy[c] || st_ff.enhAct[c])) begin
				nxt_st.busy[c] = 1'b0;
				nxt_st.status[c] = headStatus[c];
				nxt_st.rspData[c] = headData[c];
				nxt_st.counter[c] = cntNext(st_ff.counter[c]);
				nxt_st.pendRsp[c] = 1'b1;
				nxt_st.enhAct[c] = st_ff.cmdEnh[c] && !cancel[c] &&
					(headStatus[c] == STATUS_OK);
			end else if (st_ff.enhAct[c] && tagSeen[c] &&
					(!st_ff.tagVld[c] || tagId[c] != st_ff.lastTag[c])) begin
				nxt_st.tagVld[c] = 1'b1;
				nxt_st.lastTag[c] = tagId[c];
				nxt_st.status[c] = STATUS_OK;
				nxt_st.rspData[c] = tagId[c];
				nxt_st.counter[c] = cntNext(st_ff.counter[c]);
				nxt_st.pendRsp[c] = 1'b1;
			end else if (st_ff.enhAct[c] && tagLeave[c] && st_ff.tagVld[c]) begin
				nxt_st.tagVld[c] = 1'b0;
				nxt_st.status[c] = STATUS_LEFT;
				nxt_st.rspData[c] = FILL_DATA;
				nxt_st.counter[c] = cntNext(st_ff.counter[c]);
				nxt_st.pendRsp[c] = 1'b1;
			end
		end
		// soft restart: staged settings take effect, commands dropped
		if (st_ff.restartPend) begin
			nxt_st.restartPend = 1'b0;
			nxt_st.restartReq = 1'b1;
			nxt_st.ipActive = st_ff.ipStage;
			nxt_st.field = '0;
			nxt_st.seen = '0;
			nxt_st.busy = '0;
			nxt_st.enhAct = '0;
			nxt_st.tagVld = '0;
			nxt_st.pendConf = '0;
			nxt_st.pendRsp = '0;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_ff <= '0;
			st_ff.ipStage <= NET_IP_RST;
			st_ff.ipActive <= NET_IP_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign regRdData = st_ff.rdData;
	assign execStart = st_ff.execStart;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_exec
			assign execCode[g] = st_ff.seen[g][7:0];
			assign execParam[g] = st_ff.seen[g][31:16];
		end
	endgenerate
	assign txValid    = st_ff.txValid;
	assign txIsConf   = st_ff.txIsConf;
	assign txChan     = st_ff.txChan;
	assign txHasLen   = st_ff.txHasLen;
	assign txLength   = st_ff.txLength;
	assign txCode     = st_ff.txCode;
	assign txChanTog  = st_ff.txChanTog;
	assign txStatus   = st_ff.txStatus;
	assign txCounter  = st_ff.txCounter;
	assign txData     = st_ff.txData;
	assign mailReq    = st_ff.mailReq;
	assign mailChan   = st_ff.mailChan;
	assign dhcpMode   = st_ff.dhcp;
	assign netIp      = st_ff.ipActive;
	assign restartReq = st_ff.restartReq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	logic [1:0] confCnt0;
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			confCnt0 <= 2'h0;
		end else if (st_ff.execStart[0]) begin
			confCnt0 <= 2'h0;
		end else if (txValid && txIsConf && !txChan && confCnt0 != 2'h3) begin
			confCnt0 <= 2'(confCnt0 + 2'h1);
		end
	end

	property p_conf_follows;
		execStart[0] && st_ff.proto != PROTO_MODBUS && !st_ff.restartPend
			|=> txValid && txIsConf && !txChan && txStatus == STATUS_BUSY;
	endproperty
	a_conf_follows: assert property (p_conf_follows)
		else $error("no confirmation after command on channel 0");

	property p_no_conf_modbus;
		execStart[0] && st_ff.proto == PROTO_MODBUS
			|=> !(txValid && txIsConf && !txChan);
	endproperty
	a_no_conf_modbus: assert property (p_no_conf_modbus)
		else $error("confirmation sent under modbus");

	property p_one_conf;
		confCnt0 <= 2'h1;
	endproperty
	a_one_conf: assert property (p_one_conf)
		else $error("more than one confirmation for a command");

	property p_conf_frame;
		txValid && txIsConf |-> txData == FILL_DATA && txLength == CONF_LEN;
	endproperty
	a_conf_frame: assert property (p_conf_frame)
		else $error("confirmation frame malformed");

	property p_busy_count;
		newCmd[0] |=> st_ff.status[0] == STATUS_BUSY && execStart[0] &&
			st_ff.counter[0] == cntNext($past(st_ff.counter[0]));
	endproperty
	a_busy_count: assert property (p_busy_count)
		else $error("new command did not mark busy and count");

	property p_wrap;
		st_ff.counter[0] == CNT_LAST ##1 st_ff.counter[0] != CNT_LAST
			|-> st_ff.counter[0] == CNT_START;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("reply counter did not wrap to start value");

	property p_toggle_echo;
		txValid && !txChan |-> txChanTog == $past(st_ff.seen[0][15:8]);
	endproperty
	a_toggle_echo: assert property (p_toggle_echo)
		else $error("toggle byte not echoed");

	property p_single_ends;
		headDone[0] && st_ff.busy[0] && !st_ff.cmdEnh[0] && !newCmd[0]
			|=> !st_ff.busy[0] && !st_ff.enhAct[0] ##1 txValid && !txIsConf;
	endproperty
	a_single_ends: assert property (p_single_ends)
		else $error("single mode command did not finish once");

	property p_no_repeat;
		st_ff.enhAct[0] && tagSeen[0] && st_ff.tagVld[0] && !headDone[0] &&
			tagId[0] == st_ff.lastTag[0] && !newCmd[0] && !tagLeave[0]
			|=> $stable(st_ff.counter[0]);
	endproperty
	a_no_repeat: assert property (p_no_repeat)
		else $error("same tag reported twice");

	property p_leave_five;
		st_ff.enhAct[0] && st_ff.tagVld[0] && tagLeave[0] && !tagSeen[0] &&
			!headDone[0] && !newCmd[0] |=> st_ff.status[0] == STATUS_LEFT;
	endproperty
	a_leave_five: assert property (p_leave_five)
		else $error("tag leave did not give status 5");

	property p_restart;
		regWrEn && regAddr == OFS_SAVE |=> ##1 restartReq &&
			netIp == $past(st_ff.ipStage);
	endproperty
	a_restart: assert property (p_restart)
		else $error("save did not restart with staged settings");

	c_conf: cover property (txValid && txIsConf);
	c_leave: cover property (txValid && !txIsConf && txStatus == STATUS_LEFT);
	c_wrap: cover property (st_ff.counter[0] == CNT_LAST ##1
		st_ff.counter[0] == CNT_START);
	c_mail: cover property (mailReq);
endmodule : ictl_engine

// *** src/ictl_match.sv ***
// ictl_match: compares a response status with a channel's mail codes.
// assumes codes and enables come from registers on the same clock.
`timescale 1ns/1ps
module ictl_match (
	// status under test
	input  wire logic [7:0]                            status,
	// configured codes and their enables
	input  wire logic [ictl_pkg::MAIL_CODES-1:0][7:0] codes,
	input  wire logic [ictl_pkg::MAIL_CODES-1:0]      enable,
	// result
	output logic                                       hit
);
	import ictl_pkg::*;

	logic [MAIL_CODES-1:0] eq;

	genvar k;
	generate
		for (k = 0; k < MAIL_CODES; k++) begin : g_cmp
			assign eq[k] = enable[k] && (codes[k] == status);
		end
	endgenerate

	assign hit = |eq;
endmodule : ictl_match

// *** src/ictl_pkg.sv ***
// ictl_pkg: constants and types of the identification command engine.
// assumes a single 50 MHz system clock and a plain register port.
package ictl_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NUM_CH     = 2;
	localparam int MAIL_CODES = 5;
	localparam int ADDR_W     = 8;
	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_CMD   = 8'h04;
	localparam logic [7:0] OFS_STAT0 = 8'h08;
	localparam logic [7:0] OFS_STAT1 = 8'h0C;
	localparam logic [7:0] OFS_NETIP = 8'h10;
	localparam logic [7:0] OFS_NETAC = 8'h14;
	localparam logic [7:0] OFS_SAVE  = 8'h18;
	localparam logic [7:0] OFS_MAIL  = 8'h20;
	localparam logic [7:0] MAIL_STEP = 8'h08;
	localparam logic [7:0] MAIL_HI   = 8'h04;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_PROTO_LSB  = 0;
	localparam int CTRL_ENH_LSB    = 2;
	localparam int CTRL_CANCEL_LSB = 4;
	localparam int CTRL_DHCP_BIT   = 8;
	localparam int CMD_CT_LSB      = 8;
	localparam int STAT_CNT_LSB    = 8;
	localparam int STAT_BUSY_BIT   = 16;
	localparam int STAT_ENH_BIT    = 17;
	localparam int STAT_TAG_BIT    = 18;
	localparam int MAIL_MASK_LSB   = 8;
	// ------------------------------------------------------------
	// values
	// ------------------------------------------------------------
	localparam logic [7:0]  STATUS_BUSY = 8'hFF;
	localparam logic [7:0]  STATUS_OK   = 8'h00;
	localparam logic [7:0]  STATUS_LEFT = 8'h05;
	localparam logic [7:0]  CNT_RESET   = 8'h00;
	localparam logic [7:0]  CNT_START   = 8'h01;
	localparam logic [7:0]  CNT_LAST    = 8'hFF;
	localparam logic [31:0] FILL_DATA   = 32'h0000_0000;
	localparam logic [15:0] CONF_LEN    = 16'h0006;
	localparam logic [15:0] RSP_LEN     = 16'h000A;
	localparam logic [3:0]  SEL_DHCP    = 4'hD;
	localparam logic [31:0] NET_IP_RST  = 32'hA9FE_0A0C;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_NS   = 20;
	localparam int SCAN_NS  = 1000;
	localparam int SCAN_CYC = (SCAN_NS / CLK_NS < 1) ? 1 : SCAN_NS / CLK_NS;
	localparam logic [1:0] STRAP_WAIT = 2'h2;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PROTO_TCP    = 2'b00,
		PROTO_MODBUS = 2'b01,
		PROTO_CYCLIC = 2'b10
	} ictl_proto_e;
endpackage : ictl_pkg

// *** verification/ictl_head_model.sv ***
// ictl_head_model: head logic model, answers each start after a delay.
// assumes start pulses from the engine on clk_sys.
`timescale 1ns/1ps
module ictl_head_model (
	// clock and reset
	input  wire logic                              clk_sys,
	input  wire logic                              resetn,
	// engine side
	input  wire logic [ictl_pkg::NUM_CH-1:0]       execStart,
	input  wire logic [ictl_pkg::NUM_CH-1:0][7:0]  execCode,
	output logic      [ictl_pkg::NUM_CH-1:0]       headDone,
	output logic      [ictl_pkg::NUM_CH-1:0][7:0]  headStatus,
	output logic      [ictl_pkg::NUM_CH-1:0][31:0] headData
);
	import ictl_pkg::*;
	logic [NUM_CH-1:0][3:0] waitCnt;
	always_ff @(posedge clk_sys or negedge resetn) begin
		for (int c = 0; c < NUM_CH; c++) begin
			if (!resetn) begin
				waitCnt[c]  <= 4'h0;
				headDone[c] <= 1'b0;
			end else begin
				headDone[c] <= (waitCnt[c] == 4'h1);
				if (execStart[c]) waitCnt[c] <= 4'h3 + 4'(c);
				else if (waitCnt[c] != 4'h0) waitCnt[c] <= waitCnt[c] - 4'h1;
			end
		end
	end
	// outside the done pulse status and data show garbage
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			headStatus[c] = (execCode[c] == 8'h06) ? 8'h06 : 8'h00;
			headData[c]   = {24'h0, execCode[c]};
			if (!headDone[c]) headStatus[c] = ~headStatus[c];
			if (!headDone[c]) headData[c] = ~headData[c];
		end
	end
endmodule : ictl_head_model

// *** verification/testbench.sv ***
// testbench: drives commands over the register port, checks telegrams.
// assumes the head model as far side and selector held at D.
`timescale 1ns/1ps
module testbench;
	import ictl_pkg::*;
	logic clk_sys = 1'b0, resetn = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0, regRdData;
	logic [NUM_CH-1:0] execStart, headDone;
	logic [NUM_CH-1:0][7:0] execCode, headStatus;
	logic [NUM_CH-1:0][15:0] execParam;
	logic [NUM_CH-1:0][31:0] headData;
	logic txValid, txIsConf, txChan, txHasLen, mailReq, mailChan;
	logic dhcpMode, restartReq;
	logic [15:0] txLength;
	logic [7:0] txCode, txChanTog, txStatus, txCounter;
	logic [31:0] txData, netIp;
	logic [NUM_CH-1:0] tagSeen = '0, tagLeave = '0;
	logic [NUM_CH-1:0][31:0] tagId = '0;
	logic [83:0] expQ[$];
	int err_count = 0, n_compared = 0, cyc = 0;
	logic hasLen = 1'b1;
	always #10 clk_sys = ~clk_sys;
	ictl_engine dut (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData(regRdData), .addrSel(SEL_DHCP), .execStart(execStart),
		.execCode(execCode), .execParam(execParam), .headDone(headDone),
		.headStatus(headStatus), .headData(headData), .tagSeen(tagSeen),
		.tagLeave(tagLeave), .tagId(tagId), .txValid(txValid),
		.txIsConf(txIsConf), .txChan(txChan), .txHasLen(txHasLen),
		.txLength(txLength), .txCode(txCode), .txChanTog(txChanTog),
		.txStatus(txStatus), .txCounter(txCounter), .txData(txData),
		.mailReq(mailReq), .mailChan(mailChan), .dhcpMode(dhcpMode),
		.netIp(netIp), .restartReq(restartReq));
	ictl_head_model head (.clk_sys(clk_sys), .resetn(resetn),
		.execStart(execStart), .execCode(execCode), .headDone(headDone),
		.headStatus(headStatus), .headData(headData));
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic cmp(input logic [83:0] got, input logic [83:0] want);
		n_compared++;
		if (got !== want) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
		@(posedge clk_sys);
		regWrEn <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		@(posedge clk_sys);
		regAddr <= a; regRdEn <= 1'b1;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		#1 cmp({52'h0, regRdData}, {52'h0, want});
	endtask : rd
	task automatic tg(input logic [31:0] id, input logic [1:0] sn, lv);
		@(posedge clk_sys);
		tagId[0] <= id; tagSeen <= sn; tagLeave <= lv;
		@(posedge clk_sys);
		tagSeen <= 2'b00; tagLeave <= 2'b00;
	endtask : tg
	// note one telegram: conf, channel, chan/toggle, code, status, counter
	task automatic exp(input logic cf, ch, input logic [7:0] ct, cd, st, cn,
		input logic ml);
		expQ.push_back({cf, ch, hasLen, cf ? CONF_LEN : RSP_LEN, cd, ct, st,
			cn, cf ? FILL_DATA : {24'h0, cd}, ml});
	endtask : exp
	// host waits until every answer arrived before a new command
	task automatic drain();
		for (int i = 0; i < 400 && expQ.size() != 0; i++) @(posedge clk_sys);
		repeat (120) @(posedge clk_sys);
		cmp({83'h0, expQ.size() == 0}, 84'h1);
		$display("test done at %0t", $time);
	endtask : drain
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			end_sim();
		end
		if (txValid === 1'b1) begin
			if (expQ.size() == 0) cmp(84'h1, 84'h0);
			else cmp({txIsConf, txChan, txHasLen, txLength, txCode, txChanTog,
				txStatus, txCounter, txData, mailReq}, expQ.pop_front());
		end
		if (mailReq === 1'b1) cmp({83'h0, mailChan}, 84'h0);
	end
	initial begin
		logic [15:0] prm;
		logic [31:0] tag;
		void'($urandom(13));
		prm = 16'($urandom);
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd(OFS_CTRL, 32'h0000_0100);
		cmp({83'h0, dhcpMode}, 84'h1);
		rd(8'hFC, 32'h0);
		wr(OFS_MAIL, 32'h0000_0006);
		wr(OFS_MAIL + MAIL_HI, 32'h0000_0100);
		exp(1, 0, 8'h02, 8'h10, STATUS_BUSY, 8'h01, 0);
		exp(0, 0, 8'h02, 8'h10, STATUS_OK, 8'h02, 0);
		wr(OFS_CMD, {prm, 8'h02, 8'h10});
		drain();
		cmp({68'h0, execParam[0]}, {68'h0, prm});
		wr(OFS_CMD, {prm, 8'h02, 8'h10});
		drain();
		exp(1, 0, 8'h03, 8'h10, STATUS_BUSY, 8'h03, 0);
		exp(0, 0, 8'h03, 8'h10, STATUS_OK, 8'h04, 0);
		wr(OFS_CMD, {prm, 8'h03, 8'h10});
		drain();
		wr(OFS_CTRL, 32'h1);
		exp(0, 0, 8'h02, 8'h06, 8'h06, 8'h06, 1);
		wr(OFS_CMD, {~prm, 8'h02, 8'h06});
		drain();
		wr(OFS_CTRL, 32'h2);
		hasLen = 1'b0;
		exp(1, 1, 8'h04, 8'h11, STATUS_BUSY, 8'h01, 0);
		exp(0, 1, 8'h04, 8'h11, STATUS_OK, 8'h02, 0);
		wr(OFS_CMD, {prm, 8'h04, 8'h11});
		drain();
		hasLen = 1'b1;
		wr(OFS_CTRL, 32'h4);
		exp(1, 0, 8'h02, 8'h12, STATUS_BUSY, 8'h07, 0);
		exp(0, 0, 8'h02, 8'h12, STATUS_OK, 8'h08, 0);
		wr(OFS_CMD, {prm, 8'h02, 8'h12});
		drain();
		tag = $urandom;
		expQ.push_back({3'h1, RSP_LEN, 16'h1202, STATUS_OK, 8'h09, tag,
			1'b0});
		expQ.push_back({3'h1, RSP_LEN, 16'h1202, STATUS_LEFT, 8'h0A,
			FILL_DATA, 1'b0});
		tg(tag, 2'b01, 2'b00);
		tg(tag, 2'b01, 2'b00);
		tg(tag, 2'b00, 2'b01);
		drain();
		wr(OFS_CTRL, 32'h10);
		tg(~tag, 2'b01, 2'b00);
		drain();
		rd(OFS_STAT0, 32'h0000_0A05);
		wr(OFS_NETIP, tag);
		rd(OFS_NETAC, NET_IP_RST);
		wr(OFS_SAVE, 32'h0);
		@(posedge clk_sys);
		#1 cmp({51'h0, restartReq, netIp}, {51'h0, 1'b1, tag});
		end_sim();
	end
endmodule : testbench
